// file: rtl/acsc_pkg.sv
// Constants, field layouts and carrier types for the converter sequence control.
// Assumes a 32-bit APB register port and one 125 MHz bus clock.
package acsc_pkg;
  //////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] ACSC_CTRL_OFS = 8'h00;
  localparam logic [7:0] ACSC_START_OFS = 8'h04;
  localparam logic [7:0] ACSC_STAT_OFS = 8'h08;
  localparam logic [7:0] ACSC_MASK_OFS = 8'h0C;
  localparam logic [7:0] ACSC_RES_OFS = 8'h10;
  localparam logic [7:0] ACSC_RES_END = 8'h2C;
  //////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int ACSC_PSC_LSB = 0;
  localparam int ACSC_TEN_BIT = 5;
  localparam int ACSC_SMP_LSB = 6;
  localparam int ACSC_PWR_BIT = 8;
  localparam logic [8:0] ACSC_CTRL_RST = 9'h001;
  // Start register fields
  localparam int ACSC_EIGHT_BIT = 3;
  // Status and mask fields
  localparam int ACSC_SCF_BIT = 0;
  localparam int ACSC_CCF_LSB = 8;
  //////////////////////////////////////////////////////////////////////////////
  // Prescaler limit, base lengths in converter clocks, last indices
  localparam logic [4:0] ACSC_PSC_MAX = 5'h07;
  localparam logic [5:0] ACSC_BASE8 = 6'h10;
  localparam logic [5:0] ACSC_BASE10 = 6'h12;
  localparam logic [2:0] ACSC_LAST4 = 3'h3;
  localparam logic [2:0] ACSC_LAST8 = 3'h7;

  typedef enum logic [0:0] {ACSC_IDLE, ACSC_CONV} acsc_state_e;

  typedef struct packed {
    logic power_up;
    logic sample;
    logic busy;
    logic [2:0] chan;
  } acsc_ana_s;

  // Final sample period 2, 4, 8 or 16 converter clocks
  function automatic logic [5:0] acsc_samp(input logic [1:0] sel);
    return 6'h02 << sel;
  endfunction : acsc_samp
endpackage : acsc_pkg

// file: rtl/acsc_adc_seq_ctrl.sv
// Converter clock prescaler, sequence control and register file on APB.
// Assumes the analog side presents a settled result on result_i when a conversion ends.
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
module acsc_adc_seq_ctrl
  import acsc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Interrupt
  output logic irq_o,
  // Analog side
  output acsc_ana_s ana_o,
  input wire logic [9:0] result_i
);
  //////////////////////////////////////////////////////////////////////////////
  // Converter clock prescaler
  logic [8:0] ctrl_r, ctrl_nxt;
  logic [2:0] pcnt_r, pcnt_nxt;
  logic half_r, half_nxt;
  logic [4:0] psc;
  logic [2:0] eff;
  logic tick;

  always_comb begin
    psc = ctrl_r[ACSC_PSC_LSB +: 5];
    // Unlisted codes behave as the largest listed one
    eff = (psc > ACSC_PSC_MAX) ? ACSC_PSC_MAX[2:0] : psc[2:0];
    tick = (pcnt_r == eff) && half_r;
    pcnt_nxt = pcnt_r + 3'h1;
    half_nxt = half_r;
    if (pcnt_r >= eff) begin
      pcnt_nxt = 3'h0;
      half_nxt = ~half_r;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pcnt_r <= 3'h0;
      half_r <= 1'b0;
    end else begin
      pcnt_r <= pcnt_nxt;
      half_r <= half_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers and sequencer
  acsc_state_e st_r, st_nxt;
  logic [7:0] start_r, start_nxt;
  logic scf_r, scf_nxt;
  logic [7:0] ccf_r, ccf_nxt;
  logic [15:0] mask_r, mask_nxt;
  logic [2:0] idx_r, idx_nxt;
  logic [5:0] cyc_r, cyc_nxt;
  logic [9:0] res_r [8];
  logic [9:0] res_nxt [8];
  logic [31:0] prdata_nxt;
  logic wr, setup, mapped, done, last;
  logic [5:0] clen, samp;
  logic [2:0] chan;
  logic [2:0] ridx;

  always_comb begin
    ctrl_nxt = ctrl_r;
    start_nxt = start_r;
    st_nxt = st_r;
    scf_nxt = scf_r;
    ccf_nxt = ccf_r;
    mask_nxt = mask_r;
    idx_nxt = idx_r;
    cyc_nxt = cyc_r;
    res_nxt = res_r;
    prdata_nxt = prdata_o;
    wr = psel_i && penable_i && pwrite_i;
    setup = psel_i && !penable_i;
    mapped = (paddr_i[1:0] == 2'h0) && (paddr_i <= ACSC_RES_END);
    ridx = 3'(paddr_i[4:2] - 3'h4);
    samp = acsc_samp(ctrl_r[ACSC_SMP_LSB +: 2]);
    clen = (ctrl_r[ACSC_TEN_BIT] ? ACSC_BASE10 : ACSC_BASE8) + samp;
    last = (idx_r == (start_r[ACSC_EIGHT_BIT] ? ACSC_LAST8 : ACSC_LAST4));
    chan = start_r[ACSC_EIGHT_BIT] ? idx_r : {start_r[2], idx_r[1:0]};
    done = (st_r == ACSC_CONV) && tick && (cyc_r == clen - 6'h01);
    // Register writes; status bits clear on writing a one
    if (wr && paddr_i == ACSC_CTRL_OFS) begin
      ctrl_nxt = pwdata_i[8:0];
    end
    if (wr && paddr_i == ACSC_MASK_OFS) begin
      mask_nxt = {pwdata_i[ACSC_CCF_LSB +: 8], 7'h00, pwdata_i[ACSC_SCF_BIT]};
    end
    if (wr && paddr_i == ACSC_STAT_OFS) begin
      scf_nxt = scf_r & ~pwdata_i[ACSC_SCF_BIT];
      ccf_nxt = ccf_r & ~pwdata_i[ACSC_CCF_LSB +: 8];
    end
    // Conversion progress; hardware sets win over the clears above
    if (st_r == ACSC_CONV && tick) begin
      cyc_nxt = cyc_r + 6'h01;
    end
    if (done) begin
      res_nxt[idx_r] = result_i;
      ccf_nxt[idx_r] = 1'b1;
      cyc_nxt = 6'h00;
      idx_nxt = idx_r + 3'h1;
      if (last) begin
        scf_nxt = 1'b1;
        st_nxt = ACSC_IDLE;
      end
    end
    if (!ctrl_r[ACSC_PWR_BIT]) begin
      st_nxt = ACSC_IDLE;
    end
    // Start write aborts, and restarts only with the power bit set
    if (wr && paddr_i == ACSC_START_OFS) begin
      start_nxt = pwdata_i[7:0];
      scf_nxt = 1'b0;
      ccf_nxt = 8'h00;
      idx_nxt = 3'h0;
      cyc_nxt = 6'h00;
      st_nxt = ctrl_r[ACSC_PWR_BIT] ? ACSC_CONV : ACSC_IDLE;
    end
    // Read data captured in the setup cycle
    if (setup) begin
      case (paddr_i)
        ACSC_CTRL_OFS: prdata_nxt = {23'h0, ctrl_r};
        ACSC_START_OFS: prdata_nxt = {24'h0, start_r};
        ACSC_STAT_OFS: prdata_nxt = {16'h0, ccf_r, 7'h0, scf_r};
        ACSC_MASK_OFS: prdata_nxt = {16'h0, mask_r};
        default: prdata_nxt = (mapped && paddr_i >= ACSC_RES_OFS) ?
                              {22'h0, res_r[ridx]} : 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_r <= ACSC_CTRL_RST;
      start_r <= 8'h00;
      st_r <= ACSC_IDLE;
      scf_r <= 1'b0;
      ccf_r <= 8'h00;
      mask_r <= 16'h0000;
      idx_r <= 3'h0;
      cyc_r <= 6'h00;
      prdata_o <= 32'h0;
      for (int i = 0; i < 8; i++) begin
        res_r[i] <= 10'h000;
      end
    end else begin
      ctrl_r <= ctrl_nxt;
      start_r <= start_nxt;
      st_r <= st_nxt;
      scf_r <= scf_nxt;
      ccf_r <= ccf_nxt;
      mask_r <= mask_nxt;
      idx_r <= idx_nxt;
      cyc_r <= cyc_nxt;
      prdata_o <= prdata_nxt;
      res_r <= res_nxt;
    end
  end

  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;
  // Mask has the status layout, one enable per flag
  assign irq_o = |({ccf_r, 7'h00, scf_r} & mask_r);
  assign ana_o = '{power_up: ctrl_r[ACSC_PWR_BIT],
                   sample: (st_r == ACSC_CONV) && (cyc_r < samp),
                   busy: (st_r == ACSC_CONV),
                   chan: chan};

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [5:0] gap_r;
  logic [5:0] scnt_r;
  logic chg_r;

  // Sample ticks seen in the running conversion
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gap_r <= 6'h00;
      chg_r <= 1'b1;
      scnt_r <= 6'h00;
    end else begin
      gap_r <= tick ? 6'h00 : gap_r + 6'h01;
      chg_r <= (wr && paddr_i == ACSC_CTRL_OFS) ? 1'b1 : (tick ? 1'b0 : chg_r);
      if (done || (wr && paddr_i == ACSC_START_OFS)) begin
        scnt_r <= 6'h00;
      end else if (tick && ana_o.sample) begin
        scnt_r <= scnt_r + 6'h01;
      end
    end
  end

  property p_code0_div2;
    @(posedge clk_i) disable iff (!nrst_i)
      tick && !chg_r && psc == 5'h00 |-> gap_r == 6'h01;
  endproperty
  a_code0_div2: assert property (p_code0_div2) else $error("code 0 not divide by 2");

  property p_reset_div4;
    @(posedge clk_i) disable iff (!nrst_i)
      $rose(nrst_i) |-> psc == 5'h01;
  endproperty
  a_reset_div4: assert property (p_reset_div4) else $error("reset code not 1");

  property p_div_table;
    @(posedge clk_i) disable iff (!nrst_i)
      tick && !chg_r |-> gap_r == {2'h0, eff, 1'b1};
  endproperty
  a_div_table: assert property (p_div_table) else $error("wrong clock divisor");

  property p_start_runs;
    @(posedge clk_i) disable iff (!nrst_i)
      wr && paddr_i == ACSC_START_OFS && ctrl_r[ACSC_PWR_BIT] |=>
        st_r == ACSC_CONV && idx_r == 3'h0 && cyc_r == 6'h00;
  endproperty
  a_start_runs: assert property (p_start_runs) else $error("start did not begin");

  property p_start_clears;
    @(posedge clk_i) disable iff (!nrst_i)
      wr && paddr_i == ACSC_START_OFS |=> !scf_r && ccf_r == 8'h00;
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("flags not cleared");

  property p_count;
    @(posedge clk_i) disable iff (!nrst_i)
      $rose(scf_r) |-> $past(idx_r) == (start_r[ACSC_EIGHT_BIT] ? 3'h7 : 3'h3);
  endproperty
  a_count: assert property (p_count) else $error("wrong sequence length");

  property p_len8;
    @(posedge clk_i) disable iff (!nrst_i)
      done && !ctrl_r[ACSC_TEN_BIT] |-> cyc_r >= 6'd17 && cyc_r <= 6'd31;
  endproperty
  a_len8: assert property (p_len8) else $error("8-bit length out of range");

  property p_len10;
    @(posedge clk_i) disable iff (!nrst_i)
      done && ctrl_r[ACSC_TEN_BIT] |-> cyc_r >= 6'd19 && cyc_r <= 6'd33;
  endproperty
  a_len10: assert property (p_len10) else $error("10-bit length out of range");

  property p_seq_done;
    @(posedge clk_i) disable iff (!nrst_i)
      done && last && !(wr && paddr_i == ACSC_START_OFS) |=>
        scf_r && ccf_r[$past(idx_r)] && st_r == ACSC_IDLE;
  endproperty
  a_seq_done: assert property (p_seq_done) else $error("complete flag missing");

  property p_tick_gap;
    @(posedge clk_i) disable iff (!nrst_i)
      tick |=> !tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("converter clock too fast");

  property p_idx_four;
    @(posedge clk_i) disable iff (!nrst_i)
      st_r == ACSC_CONV && !start_r[ACSC_EIGHT_BIT] |-> idx_r <= ACSC_LAST4;
  endproperty
  a_idx_four: assert property (p_idx_four) else $error("four-mode index overrun");

  property p_chan_eight;
    @(posedge clk_i) disable iff (!nrst_i)
      st_r == ACSC_CONV && start_r[ACSC_EIGHT_BIT] |-> ana_o.chan == idx_r;
  endproperty
  a_chan_eight: assert property (p_chan_eight) else $error("eight-mode channel wrong");

  property p_chan_four;
    @(posedge clk_i) disable iff (!nrst_i)
      st_r == ACSC_CONV && !start_r[ACSC_EIGHT_BIT] |->
        ana_o.chan == {start_r[2], idx_r[1:0]};
  endproperty
  a_chan_four: assert property (p_chan_four) else $error("four-mode channel wrong");

  property p_store;
    @(posedge clk_i) disable iff (!nrst_i)
      done && !(wr && paddr_i == ACSC_START_OFS) |=>
        ccf_r[$past(idx_r)] && res_r[$past(idx_r)] == $past(result_i);
  endproperty
  a_store: assert property (p_store) else $error("result not stored");

  property p_samp_ticks;
    @(posedge clk_i) disable iff (!nrst_i)
      done |-> scnt_r == samp;
  endproperty
  a_samp_ticks: assert property (p_samp_ticks) else $error("sample period wrong");
endmodule : acsc_adc_seq_ctrl

// file: tb/acsc_ana_model.sv
// Behavioural model of the analog channels behind the sequence control.
// Assumes the controller samples result_o on the bus edge that ends a conversion.
`timescale 1ns/10ps
module acsc_ana_model
  import acsc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Controller side
  input wire acsc_ana_s ana_i,
  output logic [9:0] result_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Converted value names its channel; outside a sequence the line toggles
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      result_o <= 10'h000;
    end else if (ana_i.busy && ana_i.power_up) begin
      result_o <= {7'h2A, ana_i.chan};
    end else begin
      result_o <= ~result_o;
    end
  end
endmodule : acsc_ana_model

// file: tb/testbench.sv
// Self-checking bench for the converter sequence control over APB.
// Assumes the analog model above and a zero-wait APB slave.
`timescale 1ns/10ps
module testbench
  import acsc_pkg::*;
;
  logic clk_i, nrst_i, psel_i, penable_i, pwrite_i;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic pready_o, pslverr_o, irq_o, err;
  acsc_ana_s ana_o;
  logic [9:0] result_i;
  int miscompares = 0;
  int total_checks = 0;
  int n, t, lim;

  acsc_adc_seq_ctrl dut (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o),
    .ana_o(ana_o), .result_i(result_i));
  acsc_ana_model ana (.clk_i(clk_i), .nrst_i(nrst_i), .ana_i(ana_o), .result_o(result_i));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic tally_and_finish();
    if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int k;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    k = 0;
    while (pready_o !== 1'b1 && k < 100) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 100) miscompares++;
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask : apb

  // Timed sequence: sel picks sample period, ten the resolution
  task automatic run(input logic [4:0] code, input logic [1:0] sel, input logic ten,
                     input logic eight);
    int cnv, exp, div, ns, es;
    cnv = eight ? 8 : 4;
    div = 2 * (code + 1);
    exp = cnv * ((ten ? 18 : 16) + (2 << sel)) * div;
    es = cnv * (2 << sel) * div;
    apb(1'b1, ACSC_CTRL_OFS, {23'h0, 1'b1, sel, ten, code});
    apb(1'b1, ACSC_START_OFS, {28'h0, eight, 3'h0});
    t = 0;
    ns = 0;
    while (irq_o !== 1'b1 && t < 6000) begin
      @(posedge clk_i);
      t++;
      if (ana_o.sample === 1'b1) ns++;
    end
    chk(32'(t >= exp - div - 4 && t <= exp + div + 4), 32'h1);
    chk(32'(ns >= es - div - 4 && ns <= es + div + 4), 32'h1);
    apb(1'b0, ACSC_STAT_OFS, 32'h0);
    chk(rd, eight ? 32'hFF01 : 32'h0F01);
    for (int k = 0; k < cnv && ten; k++) begin
      apb(1'b0, ACSC_RES_OFS + 8'(4 * k), 32'h0);
      chk(rd, {22'h0, 7'h2A, 3'(k)});
    end
    apb(1'b1, ACSC_STAT_OFS, 32'hFF01);
  endtask : run

  initial begin
    #320000;
    miscompares++;
    tally_and_finish();
  end

  initial begin
    nrst_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    apb(1'b0, ACSC_CTRL_OFS, 32'h0);
    chk(rd, 32'h001);
    apb(1'b0, ACSC_STAT_OFS, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, ACSC_MASK_OFS, 32'h1);
    apb(1'b1, ACSC_CTRL_OFS, 32'h100);
    repeat (1250) @(posedge clk_i); // Settle after power-up
    // Divisors exceed the converter rate band at this bus clock, kept for reach
    for (int c = 0; c < 8; c++) begin
      run(5'(c), 2'(c), c >= 4, c[0]);
    end
    chk({31'h0, irq_o}, 32'h0);
    // Abort a running sequence once its first conversion is done
    apb(1'b1, ACSC_MASK_OFS, 32'h0);
    apb(1'b1, ACSC_CTRL_OFS, 32'h101);
    apb(1'b1, ACSC_START_OFS, 32'h0);
    rd = 32'h0;
    for (lim = 0; lim < 300 && rd[8] !== 1'b1; lim++) apb(1'b0, ACSC_STAT_OFS, 32'h0);
    apb(1'b1, ACSC_START_OFS, 32'h4);
    apb(1'b0, ACSC_STAT_OFS, 32'h0);
    chk(rd, 32'h0);
    for (lim = 0; lim < 300 && rd[0] !== 1'b1; lim++) apb(1'b0, ACSC_STAT_OFS, 32'h0);
    chk(rd, 32'h0F01);
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, ACSC_RES_OFS + 8'(4 * k), 32'h0);
      chk(rd, {22'h0, 7'h2A, 3'(4 + k)});
    end
    chk({31'h0, irq_o}, 32'h0);
    apb(1'b1, ACSC_MASK_OFS, 32'h100);
    chk({31'h0, irq_o}, 32'h1);
    apb(1'b1, ACSC_STAT_OFS, 32'hFFFF);
    chk({31'h0, irq_o}, 32'h0);
    apb(1'b0, ACSC_STAT_OFS, 32'h0);
    chk(rd, 32'h0);
    tally_and_finish();
  end
endmodule : testbench
